// *** src/phy_mac_side.sv ***
// What this block does
// - Frames move as 4-bit nibbles on separate transmit and receive paths, 10 or 100.
// - Received nibbles go out on rxd with rxClk, qualified by rxDv.
// - This block generates both nibble clocks toward the MAC.
// - Nibble clocks run 25 MHz at 100 Mbps and 2.5 MHz at 10 Mbps.
// - While power-on reset runs, MAC pins and line transmit stay undriven.
// - When reset completes, line transmit is enabled again, and MAC pins too unless the address is zero.
// - Management uses one two-way data line timed by the manager's clock.
// - Management port works in every MAC interface mode.
// - One consolidated status register gives key link status in one read.
// - Five pins show activity, collision, link, transmit and receive.
// - Strap pins are inputs in reset, sampled at exit, outputs afterward.
// - Software reset neither resamples straps nor changes their direction.
// - Sampled strap levels form the management address.
// - Asserted LED level is the inverse of the sampled strap level.
// - Address zero keeps the MAC data interface undriven.
module phy_mac_side (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic txClk,
   output logic rxClk,
   output logic macOe,
   input wire logic txEn,
   input wire logic [3:0] txd,
   output logic [3:0] rxd,
   output logic rxDv,
   input wire logic mdc,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   input wire logic [3:0] rxInData,
   input wire logic rxInValid,
   output logic rxInReady,
   output logic [3:0] txOutData,
   output logic txOutValid,
   output logic lineTxOe,
   input wire logic collisionInd,
   input wire logic linkGoodInd,
   input wire logic strap0ActivityLedIn,
   output logic strap0ActivityLedOut,
   output logic strap0ActivityLedOe,
   input wire logic strap1CollisionLedIn,
   output logic strap1CollisionLedOut,
   output logic strap1CollisionLedOe,
   input wire logic strap2LinkGoodLedIn,
   output logic strap2LinkGoodLedOut,
   output logic strap2LinkGoodLedOe,
   input wire logic strap3TxDataLedIn,
   output logic strap3TxDataLedOut,
   output logic strap3TxDataLedOe,
   input wire logic strap4RxDataLedIn,
   output logic strap4RxDataLedOut,
   output logic strap4RxDataLedOe
);
   typedef struct packed {
      logic [1:0] mdcSync;
      logic [1:0] mdioSync;
      logic mdcLast;
      logic [4:0] strapSync1;
      logic [4:0] strapSync2;
      logic txEnSync1;
      logic txEnSync2;
      logic [3:0] txdSync1;
      logic [3:0] txdSync2;
      logic [1:0] relCnt;
      logic strapsValid;
      logic [4:0] strapLevel;
      logic [4:0] ledOut;
      logic [4:0] divCnt;
      logic nibClk;
      logic [3:0] rxd;
      logic rxDv;
      logic [3:0] txNib;
      logic txNibValid;
      logic speed100;
      logic fullDup;
      logic [1:0] ifMode;
      phy_mac_pkg::mdState_t md;
      logic [5:0] mdCnt;
      logic [12:0] hdr;
      logic [15:0] mdData;
      logic mdRead;
      logic mdioOut;
      logic mdioOe;
      logic wbAck;
      logic [31:0] wbDat;
   } state_t;

   state_t r_reg, r_next;
   logic fifoOutValid, fifoOutReady;
   logic [3:0] fifoOutData;
   logic [4:0] strapPins;
   logic [4:0] ledInd;

   // Consolidated status word, shared by both register paths
   function automatic logic [15:0] consolStatus(input state_t s, input logic col,
      input logic link);
      logic [15:0] v;
      v = '0;
      v[phy_mac_pkg::ST_LINK] = link;
      v[phy_mac_pkg::ST_SPEED] = s.speed100;
      v[phy_mac_pkg::ST_DUP] = s.fullDup;
      v[phy_mac_pkg::ST_COL] = col;
      v[phy_mac_pkg::ST_ADDR_LO +: 5] = s.strapLevel;
      v[phy_mac_pkg::ST_VALID] = s.strapsValid;
      v[phy_mac_pkg::ST_MODE_LO +: 2] = s.ifMode;
      return v;
   endfunction : consolStatus

   assign strapPins = {strap4RxDataLedIn, strap3TxDataLedIn, strap2LinkGoodLedIn,
      strap1CollisionLedIn, strap0ActivityLedIn};

   assign ledInd = {r_reg.rxDv, r_reg.txEnSync2, linkGoodInd, collisionInd,
      r_reg.rxDv | r_reg.txEnSync2};

   // Straps drive only after their sample is held
   assign strap0ActivityLedOe = r_reg.strapsValid;
   assign strap1CollisionLedOe = r_reg.strapsValid;
   assign strap2LinkGoodLedOe = r_reg.strapsValid;
   assign strap3TxDataLedOe = r_reg.strapsValid;
   assign strap4RxDataLedOe = r_reg.strapsValid;
   assign strap0ActivityLedOut = r_reg.ledOut[0];
   assign strap1CollisionLedOut = r_reg.ledOut[1];
   assign strap2LinkGoodLedOut = r_reg.ledOut[2];
   assign strap3TxDataLedOut = r_reg.ledOut[3];
   assign strap4RxDataLedOut = r_reg.ledOut[4];

   // Isolation until straps are held, and for address zero
   assign macOe = r_reg.strapsValid && (r_reg.strapLevel != 5'h00);
   assign lineTxOe = r_reg.strapsValid;

   // Both clocks sourced here from one divider
   assign txClk = r_reg.nibClk;
   assign rxClk = r_reg.nibClk;
   assign rxd = r_reg.rxd;
   assign rxDv = r_reg.rxDv;
   assign txOutData = r_reg.txNib;
   assign txOutValid = r_reg.txNibValid;
   assign mdioOut = r_reg.mdioOut;
   assign mdioOe = r_reg.mdioOe;
   assign wb_ack_o = r_reg.wbAck;
   assign wb_dat_o = r_reg.wbDat;

   stream_fifo #(
      .WIDTH(phy_mac_pkg::NIB_W),
      .DEPTH(phy_mac_pkg::FIFO_DEPTH)
   ) rxFifo (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .inValid(rxInValid),
      .inReady(rxInReady),
      .inData(rxInData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   logic [4:0] half;
   logic toggle, rise, fall, mdcRise, bitIn, softRst;
   logic [12:0] hdrFull;
   logic [15:0] regVal;

   // Drain one nibble per falling nibble-clock edge, so the buffer backs up
   assign fifoOutReady = fall & macOe;

   always_comb
   begin
      r_next = r_reg;
      softRst = 1'b0;
      hdrFull = {r_reg.hdr[11:0], r_reg.mdioSync[1]};
      regVal = '0;

      r_next.mdcSync = {r_reg.mdcSync[0], mdc};
      r_next.mdioSync = {r_reg.mdioSync[0], mdioIn};
      r_next.mdcLast = r_reg.mdcSync[1];
      r_next.strapSync1 = strapPins;
      r_next.strapSync2 = r_reg.strapSync1;
      r_next.txEnSync1 = txEn;
      r_next.txEnSync2 = r_reg.txEnSync1;
      r_next.txdSync1 = txd;
      r_next.txdSync2 = r_reg.txdSync1;

      // Capture once after release, then hold
      if (!r_reg.strapsValid)
      begin
         if (r_reg.relCnt == phy_mac_pkg::SYNC_STAGES)
         begin
            r_next.strapLevel = r_reg.strapSync2;
            r_next.strapsValid = 1'b1;
         end
         else
         begin
            r_next.relCnt = r_reg.relCnt + 2'h1;
         end
      end
      // LED on drives the opposite of the strap
      // Uses the level being captured now, so the first driven cycle is already right
      r_next.ledOut = r_next.strapLevel ^ ledInd;

      half = r_reg.speed100 ? phy_mac_pkg::HALF_100 : phy_mac_pkg::HALF_10;
      toggle = r_reg.divCnt >= half - 5'h01;
      rise = toggle & ~r_reg.nibClk;
      fall = toggle & r_reg.nibClk;
      r_next.divCnt = toggle ? 5'h00 : r_reg.divCnt + 5'h01;
      r_next.nibClk = r_reg.nibClk ^ toggle;

      // Sample the MAC at the rising edge after the one it launched from
      r_next.txNibValid = rise & macOe & r_reg.txEnSync2;
      if (rise & macOe)
      begin
         r_next.txNib = r_reg.txdSync2;
      end

      // Receive nibbles change on the falling edge
      if (!macOe)
      begin
         r_next.rxDv = 1'b0;
         r_next.rxd = 4'h0;
      end
      else if (fall)
      begin
         r_next.rxDv = fifoOutValid;
         r_next.rxd = fifoOutValid ? fifoOutData : 4'h0;
      end

      // Management frames, bit-timed by the manager's clock only
      mdcRise = r_reg.mdcSync[1] & ~r_reg.mdcLast;
      bitIn = r_reg.mdioSync[1];
      if (mdcRise)
      begin
         case (r_reg.md)
            phy_mac_pkg::MD_PRE:
            begin
               if (bitIn)
               begin
                  if (r_reg.mdCnt != phy_mac_pkg::PREAMBLE_LEN)
                  begin
                     r_next.mdCnt = r_reg.mdCnt + 6'h01;
                  end
               end
               else if (r_reg.mdCnt == phy_mac_pkg::PREAMBLE_LEN)
               begin
                  r_next.md = phy_mac_pkg::MD_HDR;
                  r_next.mdCnt = 6'h01;
               end
               else
               begin
                  r_next.mdCnt = 6'h00;
               end
            end
            phy_mac_pkg::MD_HDR:
            begin
               r_next.hdr = hdrFull;
               r_next.mdCnt = r_reg.mdCnt + 6'h01;
               if (r_reg.mdCnt == phy_mac_pkg::HDR_BITS)
               begin
                  r_next.mdCnt = 6'h00;
                  r_next.md = phy_mac_pkg::MD_PRE;
                  if (hdrFull[12] && r_reg.strapsValid
                     && hdrFull[9:5] == r_reg.strapLevel)
                  begin
                     // Consolidated status in a single read
                     case (hdrFull[4:0])
                        phy_mac_pkg::MREG_CTRL:
                        begin
                           regVal[phy_mac_pkg::MC_SPEED] = r_reg.speed100;
                           regVal[phy_mac_pkg::MC_DUP] = r_reg.fullDup;
                        end
                        phy_mac_pkg::MREG_STATUS:
                        begin
                           regVal[phy_mac_pkg::MS_LINK] = linkGoodInd;
                        end
                        phy_mac_pkg::MREG_CONSOL:
                        begin
                           regVal = consolStatus(r_reg, collisionInd, linkGoodInd);
                        end
                        default:
                        begin
                           regVal = '0;
                        end
                     endcase
                     if (hdrFull[11:10] == phy_mac_pkg::OP_READ
                        || hdrFull[11:10] == phy_mac_pkg::OP_WRITE)
                     begin
                        r_next.md = phy_mac_pkg::MD_TA;
                        r_next.mdRead = hdrFull[11:10] == phy_mac_pkg::OP_READ;
                        r_next.mdData = regVal;
                     end
                  end
               end
            end
            phy_mac_pkg::MD_TA:
            begin
               r_next.mdCnt = r_reg.mdCnt + 6'h01;
               if (r_reg.mdCnt == 6'h00)
               begin
                  r_next.mdioOe = r_reg.mdRead;
                  r_next.mdioOut = 1'b0;
               end
               else
               begin
                  r_next.md = phy_mac_pkg::MD_DATA;
                  r_next.mdCnt = 6'h00;
                  r_next.mdioOut = r_reg.mdData[15];
                  if (r_reg.mdRead)
                  begin
                     r_next.mdData = {r_reg.mdData[14:0], 1'b0};
                  end
               end
            end
            phy_mac_pkg::MD_DATA:
            begin
               r_next.mdCnt = r_reg.mdCnt + 6'h01;
               if (r_reg.mdRead)
               begin
                  r_next.mdioOut = r_reg.mdData[15];
                  r_next.mdData = {r_reg.mdData[14:0], 1'b0};
               end
               else
               begin
                  r_next.mdData = {r_reg.mdData[14:0], bitIn};
               end
               if (r_reg.mdCnt == phy_mac_pkg::DATA_BITS - 6'h01)
               begin
                  r_next.md = phy_mac_pkg::MD_PRE;
                  r_next.mdCnt = 6'h00;
                  r_next.mdioOe = 1'b0;
                  r_next.mdioOut = 1'b0;
                  if (!r_reg.mdRead && r_reg.hdr[4:0] == phy_mac_pkg::MREG_CTRL)
                  begin
                     r_next.speed100 = r_reg.mdData[phy_mac_pkg::MC_SPEED - 1];
                     r_next.fullDup = r_reg.mdData[phy_mac_pkg::MC_DUP - 1];
                     softRst = r_reg.mdData[phy_mac_pkg::MC_SOFTRST - 1];
                  end
               end
            end
            default:
            begin
               r_next.md = phy_mac_pkg::MD_PRE;
               r_next.mdCnt = 6'h00;
               r_next.mdioOe = 1'b0;
            end
         endcase
      end

      // Wishbone slave: one wait state, unmapped reads zero
      r_next.wbAck = wb_cyc_i & wb_stb_i & ~r_reg.wbAck;
      if (wb_cyc_i & wb_stb_i & ~r_reg.wbAck)
      begin
         r_next.wbDat = 32'h0000_0000;
         case (wb_adr_i)
            phy_mac_pkg::ADR_CTRL:
            begin
               r_next.wbDat[phy_mac_pkg::CTRL_SPEED100] = r_reg.speed100;
               r_next.wbDat[phy_mac_pkg::CTRL_FULLDUP] = r_reg.fullDup;
               r_next.wbDat[phy_mac_pkg::CTRL_MODE_LO +: 2] = r_reg.ifMode;
               if (wb_we_i & wb_sel_i[0])
               begin
                  r_next.speed100 = wb_dat_i[phy_mac_pkg::CTRL_SPEED100];
                  r_next.fullDup = wb_dat_i[phy_mac_pkg::CTRL_FULLDUP];
                  r_next.ifMode = wb_dat_i[phy_mac_pkg::CTRL_MODE_LO +: 2];
                  softRst = wb_dat_i[phy_mac_pkg::CTRL_SOFTRST];
               end
            end
            phy_mac_pkg::ADR_STATUS:
            begin
               r_next.wbDat[15:0] = consolStatus(r_reg, collisionInd, linkGoodInd);
            end
            phy_mac_pkg::ADR_STRAP:
            begin
               r_next.wbDat[4:0] = r_reg.strapLevel;
               r_next.wbDat[5] = r_reg.strapsValid;
            end
            default:
            begin
               r_next.wbDat = 32'h0000_0000;
            end
         endcase
      end

      // Software reset restores control and restarts the nibble divider; straps keep level and direction
      if (softRst)
      begin
         r_next.speed100 = phy_mac_pkg::CTRL_SPEED_RST;
         r_next.fullDup = phy_mac_pkg::CTRL_DUP_RST;
         r_next.ifMode = phy_mac_pkg::CTRL_MODE_RST;
         r_next.divCnt = 5'h00;
         r_next.nibClk = 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         r_reg <= '0;
         r_reg.speed100 <= phy_mac_pkg::CTRL_SPEED_RST;
         r_reg.fullDup <= phy_mac_pkg::CTRL_DUP_RST;
         r_reg.ifMode <= phy_mac_pkg::CTRL_MODE_RST;
         r_reg.md <= phy_mac_pkg::MD_PRE;
      end
      else
      begin
         r_reg <= r_next;
      end
   end
endmodule : phy_mac_side

// *** src/phy_mac_pkg.sv ***
package phy_mac_pkg;
   // System clock and nibble clock rates
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int NIB_HZ_100 = 25_000_000;
   localparam int NIB_HZ_10 = 2_500_000;
   localparam logic [4:0] HALF_100 = 5'(SYS_CLK_HZ / (2 * NIB_HZ_100));
   localparam logic [4:0] HALF_10 = 5'(SYS_CLK_HZ / (2 * NIB_HZ_10));
   // Synchroniser depth, counted before straps are trusted
   localparam logic [1:0] SYNC_STAGES = 2'h2;
   // Receive buffer shape
   localparam int NIB_W = 4;
   localparam int FIFO_DEPTH = 16;
   // Wishbone byte offsets
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_STATUS = 4'h4;
   localparam logic [3:0] ADR_STRAP = 4'h8;
   // Control register fields
   localparam int CTRL_SPEED100 = 0;
   localparam int CTRL_FULLDUP = 1;
   localparam int CTRL_SOFTRST = 2;
   localparam int CTRL_MODE_LO = 3;
   localparam logic CTRL_SPEED_RST = 1'b1;
   localparam logic CTRL_DUP_RST = 1'b0;
   localparam logic [1:0] CTRL_MODE_RST = 2'h0;
   // Consolidated status field positions
   localparam int ST_LINK = 0;
   localparam int ST_SPEED = 1;
   localparam int ST_DUP = 2;
   localparam int ST_COL = 3;
   localparam int ST_ADDR_LO = 4;
   localparam int ST_VALID = 9;
   localparam int ST_MODE_LO = 10;
   // Management frame
   localparam logic [5:0] PREAMBLE_LEN = 6'h20;
   localparam logic [5:0] HDR_BITS = 6'h0D;
   localparam logic [5:0] DATA_BITS = 6'h10;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [4:0] MREG_CTRL = 5'h00;
   localparam logic [4:0] MREG_STATUS = 5'h01;
   localparam logic [4:0] MREG_CONSOL = 5'h11;
   localparam int MC_SOFTRST = 15;
   localparam int MC_SPEED = 13;
   localparam int MC_DUP = 8;
   localparam int MS_LINK = 2;
   typedef enum logic [3:0] {
      MD_PRE = 4'h1,
      MD_HDR = 4'h2,
      MD_TA = 4'h4,
      MD_DATA = 4'h8
   } mdState_t;
endpackage : phy_mac_pkg

// *** src/stream_fifo.sv ***
module stream_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrIdx;
      logic [AW-1:0] rdIdx;
      logic [AW:0] cnt;
   } fifo_t;
   fifo_t r_reg, r_next;
   logic push, pop;
   assign inReady = r_reg.cnt != (AW+1)'(DEPTH);
   assign outValid = r_reg.cnt != '0;
   assign outData = r_reg.mem[r_reg.rdIdx];
   always_comb
   begin
      r_next = r_reg;
      push = inValid & inReady;
      pop = outValid & outReady;
      if (push)
      begin
         r_next.mem[r_reg.wrIdx] = inData;
         r_next.wrIdx = r_reg.wrIdx + 1'b1;
      end
      if (pop)
      begin
         r_next.rdIdx = r_reg.rdIdx + 1'b1;
      end
      r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         r_reg <= '0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end
endmodule : stream_fifo

// *** dv/phy_mac_side_properties.sv ***
module phy_mac_side_properties (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic txClk,
   input wire logic rxClk,
   input wire logic macOe,
   input wire logic rxDv,
   input wire logic mdioOut,
   input wire logic mdioOe,
   input wire logic lineTxOe,
   input wire logic strap0ActivityLedOe,
   input wire logic strap4RxDataLedOe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   a_reset_quiet: assert property ($rose(resetn) |-> !macOe && !lineTxOe)
      else $error("outputs active at reset release");
   a_strap_release: assert property ($rose(resetn) |-> ##[1:4]
      (lineTxOe && strap0ActivityLedOe && strap4RxDataLedOe))
      else $error("pins not enabled after capture");
   a_strap_hold: assert property (strap4RxDataLedOe |=> strap4RxDataLedOe)
      else $error("strap pin left output mode");
   a_mii_isolated: assert property (!macOe && !$past(macOe) |-> !rxDv)
      else $error("receive valid while isolated");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_clk_pair: assert property (txClk == rxClk)
      else $error("nibble clocks differ");
   // Register writes may restart the divider, so edges next to an ack are excluded
   a_clk_half: assert property ($changed(txClk) && !wb_ack_o && !$past(wb_ack_o)
      |=> $stable(txClk) || wb_ack_o)
      else $error("nibble clock half period too short");
   a_rx_edge: assert property ($changed(rxDv) && macOe && $past(macOe) |-> !rxClk)
      else $error("receive valid changed while clock high");
   a_mdio_turn: assert property ($rose(mdioOe) |-> !mdioOut)
      else $error("turnaround bit not zero");
endmodule : phy_mac_side_properties

bind phy_mac_side phy_mac_side_properties props (.sys_clk(sys_clk), .resetn(resetn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .txClk(txClk),
   .rxClk(rxClk), .macOe(macOe), .rxDv(rxDv), .mdioOut(mdioOut), .mdioOe(mdioOe),
   .lineTxOe(lineTxOe), .strap0ActivityLedOe(strap0ActivityLedOe),
   .strap4RxDataLedOe(strap4RxDataLedOe));

// *** dv/mac_model.sv ***
module mac_model (
   input wire logic sys_clk,
   input wire logic txClk,
   input wire logic rxClk,
   input wire logic [3:0] rxd,
   input wire logic rxDv,
   output logic txEn,
   output logic [3:0] txd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] txQ[$];
   logic [3:0] rxQ[$];
   logic txPrev = 1'b0;
   logic rxPrev = 1'b0;
   initial
   begin
      txEn = 1'b0;
      txd = 4'h0;
   end
   always @(posedge sys_clk)
   begin
      txPrev <= txClk;
      rxPrev <= rxClk;
      if (txClk && !txPrev)
      begin
         txEn <= (txQ.size() > 0);
         // Idle data keeps moving so a stray sample cannot look valid
         txd <= (txQ.size() > 0) ? txQ.pop_front() : ~txd;
      end
      if (rxClk && !rxPrev && rxDv)
         rxQ.push_back(rxd);
   end
endmodule : mac_model

// *** dv/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] ADDR = 5'h16;
   localparam logic [9:0] EXPST = {1'b1, ADDR, 4'hD};
   localparam logic [23:0] FRAME = 24'hA5_0F3C;
   logic sys_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0] wb_adr_i, wb_sel_i, txd, rxd, rxInData, txOutData;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic txClk, rxClk, macOe, txEn, rxDv, mdc, mdioIn, mdioOut, mdioOe, mdioTb;
   logic rxInValid, rxInReady, txOutValid, lineTxOe, collisionInd, linkGoodInd;
   logic [4:0] strapPull, strapPin, ledOut, ledOe;
   logic [15:0] md;
   logic ta, ok;
   int failCount = 0;
   int samplesChecked = 0;
   int n, got;
   logic [3:0] txSeen[$];
   phy_mac_side uut (.sys_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .txClk, .rxClk, .macOe, .txEn, .txd,
      .rxd, .rxDv, .mdc, .mdioIn, .mdioOut, .mdioOe, .rxInData, .rxInValid, .rxInReady,
      .txOutData, .txOutValid, .lineTxOe, .collisionInd, .linkGoodInd,
      .strap0ActivityLedIn(strapPin[0]), .strap0ActivityLedOut(ledOut[0]),
      .strap0ActivityLedOe(ledOe[0]), .strap1CollisionLedIn(strapPin[1]),
      .strap1CollisionLedOut(ledOut[1]), .strap1CollisionLedOe(ledOe[1]),
      .strap2LinkGoodLedIn(strapPin[2]), .strap2LinkGoodLedOut(ledOut[2]),
      .strap2LinkGoodLedOe(ledOe[2]), .strap3TxDataLedIn(strapPin[3]),
      .strap3TxDataLedOut(ledOut[3]), .strap3TxDataLedOe(ledOe[3]),
      .strap4RxDataLedIn(strapPin[4]), .strap4RxDataLedOut(ledOut[4]),
      .strap4RxDataLedOe(ledOe[4]));
   mac_model mac (.sys_clk, .txClk, .rxClk, .rxd, .rxDv, .txEn, .txd);
   // Pins show the pull level whenever nobody drives them
   assign strapPin = (ledOe & ledOut) | (~ledOe & strapPull);
   assign mdioIn = mdioOe ? mdioOut : mdioTb;
   always @(posedge sys_clk)
      if (txOutValid === 1'b1)
         txSeen.push_back(txOutData);
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      samplesChecked++;
      if (g !== e)
      begin
         failCount++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1 && n < 50)
      begin
         @(posedge sys_clk);
         n++;
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge sys_clk);
      chk(32'(n < 50), 32'h0000_0001);
   endtask : wb
   task hw_reset(input logic [4:0] a);
      strapPull <= a;
      resetn <= 1'b0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask : hw_reset
   task mdio_bit(input logic b, output logic s);
      mdc <= 1'b0;
      mdioTb <= b;
      repeat (7) @(posedge sys_clk);
      @(negedge sys_clk);
      s = mdioIn;
      @(posedge sys_clk);
      mdc <= 1'b1;
      repeat (8) @(posedge sys_clk);
   endtask : mdio_bit
   task mdio_read(input logic [4:0] a);
      logic [45:0] hdr;
      logic s;
      hdr = {32'hFFFF_FFFF, 2'b01, phy_mac_pkg::OP_READ, a, phy_mac_pkg::MREG_CONSOL};
      for (int i = 45; i >= 0; i--)
         mdio_bit(hdr[i], s);
      mdio_bit(1'b1, s);
      mdio_bit(1'b1, ta);
      for (int i = 15; i >= 0; i--)
      begin
         mdio_bit(1'b1, s);
         md[i] = s;
      end
      mdio_bit(1'b1, s);
      mdc <= 1'b0;
   endtask : mdio_read
   task clk_period;
      realtime t;
      @(posedge txClk);
      t = $realtime;
      @(posedge txClk);
      n = int'(($realtime - t) / 10.0);
      @(posedge sys_clk);
   endtask : clk_period
   task endOfTest;
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : endOfTest
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      failCount++;
      endOfTest();
   end
   initial
   begin
      resetn = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0000_0000;
      mdc = 1'b0;
      mdioTb = 1'b1;
      rxInData = 4'h0;
      rxInValid = 1'b0;
      collisionInd = 1'b0;
      linkGoodInd = 1'b0;
      strapPull = ADDR;
      hw_reset(ADDR);
      wb(1'b0, phy_mac_pkg::ADR_STRAP, 32'h0);
      chk(q, {26'h0, 1'b1, ADDR});
      chk(32'(ledOe), 32'h0000_001F);
      chk(32'(ledOut), 32'(ADDR));
      chk(32'({macOe, lineTxOe}), 32'h0000_0003);
      wb(1'b0, phy_mac_pkg::ADR_CTRL, 32'h0);
      chk(q, 32'h0000_0001);
      wb(1'b0, 4'hC, 32'h0);
      chk(q, 32'h0000_0000);
      wb(1'b1, phy_mac_pkg::ADR_CTRL, 32'h0000_001A);
      wb(1'b0, phy_mac_pkg::ADR_CTRL, 32'h0);
      chk(q, 32'h0000_001A);
      linkGoodInd <= 1'b1;
      collisionInd <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(32'(ledOut), 32'(ADDR ^ 5'h06));
      wb(1'b0, phy_mac_pkg::ADR_STATUS, 32'h0);
      chk(32'(q[9:0]), 32'(EXPST));
      clk_period();
      chk(32'(n), 32'(2 * phy_mac_pkg::HALF_10));
      mdio_read(ADDR);
      chk(32'({ta, md[9:0]}), 32'(EXPST));
      got = 0;
      ok = 1'b1;
      while (ok === 1'b1 && got < 40)
      begin
         rxInValid <= 1'b1;
         rxInData <= got[3:0];
         @(negedge sys_clk);
         ok = rxInReady;
         @(posedge sys_clk);
         if (ok === 1'b1)
            got++;
      end
      rxInValid <= 1'b0;
      chk(32'(got >= 16 && got < 40), 32'h0000_0001);
      n = 0;
      while (mac.rxQ.size() < got && n < 3000)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(mac.rxQ.size()), 32'(got));
      for (int i = 0; i < mac.rxQ.size(); i++)
         chk(32'(mac.rxQ[i]), 32'(i % 16));
      chk(32'(rxInReady), 32'h0000_0001);
      wb(1'b1, phy_mac_pkg::ADR_CTRL, 32'h0000_0004);
      wb(1'b0, phy_mac_pkg::ADR_CTRL, 32'h0);
      chk(q, 32'h0000_0001);
      wb(1'b0, phy_mac_pkg::ADR_STRAP, 32'h0);
      chk(q, {26'h0, 1'b1, ADDR});
      chk(32'(ledOe), 32'h0000_001F);
      clk_period();
      chk(32'(n), 32'(2 * phy_mac_pkg::HALF_100));
      for (int i = 5; i >= 0; i--)
         mac.txQ.push_back(FRAME[i*4 +: 4]);
      repeat (80) @(posedge sys_clk);
      chk(32'(txSeen.size()), 32'h0000_0006);
      for (int j = 0; j < txSeen.size(); j++)
         chk(32'(txSeen[j]), 32'(FRAME[(5-j)*4 +: 4]));
      mdio_read(ADDR ^ 5'h01);
      chk(32'({ta, md}), 32'h0001_FFFF);
      hw_reset(5'h00);
      chk(32'({macOe, lineTxOe}), 32'h0000_0001);
      hw_reset(ADDR);
      wb(1'b0, phy_mac_pkg::ADR_STRAP, 32'h0);
      chk(q, {26'h0, 1'b1, ADDR});
      endOfTest();
   end
endmodule : tb_top
